// File: common/vwd_pkg.sv
// shared constants for the video window and decimation block
package vwd_pkg;
    // register byte offsets
    localparam logic [7:0] VWD_CTRL_OFS     = 8'h00;
    localparam logic [7:0] VWD_HDLY_OFS     = 8'h04;
    localparam logic [7:0] VWD_HWID_OFS     = 8'h08;
    localparam logic [7:0] VWD_VDLY_OFS     = 8'h0C;
    localparam logic [7:0] VWD_VLIN_OFS     = 8'h10;
    localparam logic [7:0] VWD_WMSB_OFS     = 8'h14;
    localparam logic [7:0] VWD_SKIP_OFS     = 8'h18;
    localparam logic [7:0] VWD_HUE_OFS      = 8'h1C;
    localparam logic [7:0] VWD_CONT_OFS     = 8'h20;
    localparam logic [7:0] VWD_UGAIN_OFS    = 8'h24;
    localparam logic [7:0] VWD_VGAIN_OFS    = 8'h28;
    localparam logic [7:0] VWD_STAT_OFS     = 8'h2C;
    // control register bits
    localparam int VWD_CTRL_PAL      = 0;
    localparam int VWD_CTRL_PPOUT    = 1;
    localparam int VWD_CTRL_PPIN     = 2;
    // window msb register field positions (two bits each)
    localparam int VWD_WMSB_HWID     = 0;
    localparam int VWD_WMSB_HDLY     = 2;
    localparam int VWD_WMSB_VLIN     = 4;
    localparam int VWD_WMSB_VDLY     = 6;
    // temporal skip control fields
    localparam int VWD_SKIP_FIELD    = 7;
    localparam int VWD_SKIP_ALIGN    = 6;
    // status fields
    localparam int VWD_STAT_ACC      = 16;
    localparam int VWD_STAT_SKIP     = 24;
    localparam int VWD_STAT_HACT     = 25;
    localparam int VWD_STAT_VACT     = 26;
    // reset values
    localparam logic [7:0] VWD_CONT_RST  = 8'h00;
    localparam logic [8:0] VWD_GAIN_RST  = 9'h100;
    // line and sequence figures
    localparam logic [10:0] VWD_LINE_NTSC = 11'd910;
    localparam logic [10:0] VWD_LINE_PAL  = 11'd1135;
    localparam logic [6:0]  VWD_SEQ_NTSC  = 7'd60;
    localparam logic [6:0]  VWD_SEQ_PAL   = 7'd50;
    // hue limit: 64 steps of 256 per turn is a quarter turn
    localparam logic signed [7:0] VWD_HUE_MAX = 8'sh40;
    // axi responses
    localparam logic [1:0] VWD_RESP_OKAY   = 2'b00;
    localparam logic [1:0] VWD_RESP_SLVERR = 2'b10;
endpackage

// File: hdl/vwd_top.sv
// video output window, temporal skip and colour adjust with axi4-lite regs
`timescale 1ns/100ps
// Function
// - capture starts horiz_start_delay pixels after sync
// - horizontal active rises delay pixels after sync fall
// - even delay gives Cb first, odd Cr
// - horizontal in scaled pixels, vertical unscaled half lines
// - window width sets active pixels per line
// - front porch is total minus delay minus width
// - capture starts vert delay half lines after serration
// - vertical active rises delay half lines after sync
// - vertical lines count gives source lines per frame
// - pixel port input mode ignores window registers
// - skip count gives skipped units per sequence
// - skipped unit holds active output low throughout
// - skipped units spread evenly through sequence
// - setting 0x9E outputs every odd field in ntsc mode
// - zero setting disables decimation entirely
// - writing zero resets the sequence counter
// - sequence counter cleared at reset
// - field align bit picks parity dropped first
// - hue shifts ntsc chroma phase up to quarter turn
// - luma scaled by 9-bit contrast coefficient
// - u and v scaled by separate gains
// - window values are 10 bits, msbs shared
module vwd_top
    import vwd_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        PIX_EN,
    input  wire logic        HSYNC_N,
    input  wire logic        VSYNC_N,
    input  wire logic        HALF_LINE,
    input  wire logic        FIELD_ODD,
    input  wire logic [7:0]  Y_IN,
    input  wire logic [7:0]  U_IN,
    input  wire logic [7:0]  V_IN,
    input  wire logic [7:0]  PHASE_IN,
    output logic [7:0]       Y_OUT,
    output logic [7:0]       U_OUT,
    output logic [7:0]       V_OUT,
    output logic [7:0]       PHASE_OUT,
    output logic             PIX_VALID,
    output logic             CHROMA_IS_CR,
    output logic             HORIZ_WINDOW_WIDTH_OUT,
    output logic             VERT_WINDOW_LINES_OUT,
    output logic             ACTIVE_OUT
);
    // all state in one record
    typedef struct packed {
        logic [2:0]  ctrl;      // mode bits
        logic [7:0]  hd_lo;     // low byte of horiz_start_delay
        logic [7:0]  hw_lo;     // low byte of horiz_window_width
        logic [7:0]  vd_lo;     // low byte of vert_start_delay
        logic [7:0]  vl_lo;     // low byte of vert_window_lines
        logic [7:0]  wmsb;      // window_msb_register
        logic [7:0]  skipc;     // temporal_skip_control
        logic [7:0]  hue;       // signed phase offset
        logic [8:0]  cont;      // luma gain
        logic [8:0]  ug;        // u_gain
        logic [8:0]  vg;        // v_gain
        logic [7:0]  awaddr;    // latched write address
        logic        aw_got;    // address held
        logic [31:0] wdata;     // latched write data
        logic [3:0]  wstrb;     // latched strobes
        logic        w_got;     // data held
        logic        bvalid;    // write answer pending
        logic [1:0]  bresp;     // write answer code
        logic        rvalid;    // read answer pending
        logic [31:0] rdata;     // read answer data
        logic [1:0]  rresp;     // read answer code
        logic        hs_d, vs_d; // previous sync levels
        logic [10:0] hcnt;      // scaled pixels since sync fall
        logic [10:0] vcnt;      // half lines since vertical sync rise
        logic [5:0]  acc;       // sequence accumulator
        logic        armed;     // sequence started
        logic        skip;      // current unit dropped
        logic [7:0]  y, u, v, ph; // output pixel and phase
        logic        pv;        // pixel valid
        logic        cr;        // chroma slot
        logic        hact, vact, act; // window strobes
    } vwd_state_s;
    vwd_state_s st_reg;         // registered state
    vwd_state_s st_next;        // next state
    // joins a two-bit msb field onto a low byte
    function automatic logic [10:0] vwd_join(input logic [7:0] msb,
                                             input int pos,
                                             input logic [7:0] lo);
        vwd_join = {1'b0, msb[pos+1], msb[pos], lo};
    endfunction
    // clamps a signed product down to a signed byte
    function automatic logic [7:0] vwd_sat_s(input logic signed [17:0] p);
        logic signed [17:0] q;
        q = p >>> 8;
        // saturate rather than wrap, so strong gains stay in range
        vwd_sat_s = (q > 18'sd127) ? 8'h7F
                    : (q < -18'sd128) ? 8'h80 : q[7:0];
    endfunction
    // decoded window bounds: delay, width, delay and lines
    logic [10:0] hd_w, hw_w, vd_w, vl_w;
    logic [10:0] porch_w;       // front porch
    logic [6:0]  seq_w;         // sequence length
    logic [6:0]  sum_w;         // accumulator plus count
    logic        h_in, v_in;    // inside the window
    logic        hs_fall, vs_rise; // sync edges
    logic [16:0] yprod;         // luma product
    logic [7:0]  hue_c;         // clamped hue
    logic        wr_zero;       // zero write to skip control
    // a zero write restarts the skip sequence
    assign wr_zero = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid
                     && st_reg.awaddr == VWD_SKIP_OFS && st_reg.wstrb[0]
                     && st_reg.wdata[5:0] == 6'd0;
    // window decode and sequence arithmetic
    always_comb begin
        hd_w = vwd_join(st_reg.wmsb, VWD_WMSB_HDLY, st_reg.hd_lo);
        hw_w = vwd_join(st_reg.wmsb, VWD_WMSB_HWID, st_reg.hw_lo);
        vd_w = vwd_join(st_reg.wmsb, VWD_WMSB_VDLY, st_reg.vd_lo);
        vl_w = vwd_join(st_reg.wmsb, VWD_WMSB_VLIN, st_reg.vl_lo);
        // porch only reported; may wrap if software overcrops
        porch_w = (st_reg.ctrl[VWD_CTRL_PAL] ? VWD_LINE_PAL : VWD_LINE_NTSC)
                  - hd_w - hw_w;
        seq_w = st_reg.ctrl[VWD_CTRL_PAL] ? VWD_SEQ_PAL : VWD_SEQ_NTSC;
        sum_w = {1'b0, st_reg.acc} + {1'b0, st_reg.skipc[5:0]};
        // counts are scaled pixels and unscaled half lines
        h_in = (st_reg.hcnt >= hd_w) && (st_reg.hcnt < hd_w + hw_w);
        // per field the frame line count equals its half lines
        v_in = (st_reg.vcnt >= vd_w) && (st_reg.vcnt < vd_w + vl_w);
        if (st_reg.ctrl[VWD_CTRL_PPIN]) begin
            h_in = 1'b1;
            v_in = 1'b1;
        end
        hs_fall = st_reg.hs_d && !HSYNC_N;
        vs_rise = !st_reg.vs_d && VSYNC_N;
        yprod = {9'h000, Y_IN} * {8'h00, st_reg.cont};
        hue_c = ($signed(st_reg.hue) > VWD_HUE_MAX) ? VWD_HUE_MAX
                : ($signed(st_reg.hue) < -VWD_HUE_MAX) ? -VWD_HUE_MAX
                : st_reg.hue;
    end
    // next-state logic for bus, counters and pixel path
    always_comb begin
        logic [31:0] wv;
        logic        unit;
        wv = st_reg.wdata;
        unit = 1'b0;
        st_next = st_reg;
        // write address and data taken in either order
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            st_next.awaddr = S_AXI_AWADDR;
            st_next.aw_got = 1'b1;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            st_next.wdata = S_AXI_WDATA;
            st_next.wstrb = S_AXI_WSTRB;
            st_next.w_got = 1'b1;
        end
        if (S_AXI_BVALID && S_AXI_BREADY)
            st_next.bvalid = 1'b0;
        // both halves held: commit and answer
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = VWD_RESP_OKAY;
            case (st_reg.awaddr)
                VWD_CTRL_OFS: if (st_reg.wstrb[0]) st_next.ctrl = wv[2:0];
                VWD_HDLY_OFS: if (st_reg.wstrb[0]) st_next.hd_lo = wv[7:0];
                VWD_HWID_OFS: if (st_reg.wstrb[0]) st_next.hw_lo = wv[7:0];
                VWD_VDLY_OFS: if (st_reg.wstrb[0]) st_next.vd_lo = wv[7:0];
                VWD_VLIN_OFS: if (st_reg.wstrb[0]) st_next.vl_lo = wv[7:0];
                VWD_WMSB_OFS: if (st_reg.wstrb[0]) st_next.wmsb = wv[7:0];
                VWD_SKIP_OFS: if (st_reg.wstrb[0]) st_next.skipc = wv[7:0];
                VWD_HUE_OFS:  if (st_reg.wstrb[0]) st_next.hue = wv[7:0];
                VWD_CONT_OFS: begin
                    if (st_reg.wstrb[0]) st_next.cont[7:0] = wv[7:0];
                    if (st_reg.wstrb[1]) st_next.cont[8] = wv[8];
                end
                VWD_UGAIN_OFS: begin
                    if (st_reg.wstrb[0]) st_next.ug[7:0] = wv[7:0];
                    if (st_reg.wstrb[1]) st_next.ug[8] = wv[8];
                end
                VWD_VGAIN_OFS: begin
                    if (st_reg.wstrb[0]) st_next.vg[7:0] = wv[7:0];
                    if (st_reg.wstrb[1]) st_next.vg[8] = wv[8];
                end
                VWD_STAT_OFS: ;  // read only, write ignored
                default: st_next.bresp = VWD_RESP_SLVERR;
            endcase
        end
        // read answers one cycle after the address is taken
        if (S_AXI_RVALID && S_AXI_RREADY)
            st_next.rvalid = 1'b0;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = VWD_RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            case (S_AXI_ARADDR)
                VWD_CTRL_OFS:  st_next.rdata[2:0] = st_reg.ctrl;
                VWD_HDLY_OFS:  st_next.rdata[7:0] = st_reg.hd_lo;
                VWD_HWID_OFS:  st_next.rdata[7:0] = st_reg.hw_lo;
                VWD_VDLY_OFS:  st_next.rdata[7:0] = st_reg.vd_lo;
                VWD_VLIN_OFS:  st_next.rdata[7:0] = st_reg.vl_lo;
                VWD_WMSB_OFS:  st_next.rdata[7:0] = st_reg.wmsb;
                VWD_SKIP_OFS:  st_next.rdata[7:0] = st_reg.skipc;
                VWD_HUE_OFS:   st_next.rdata[7:0] = st_reg.hue;
                VWD_CONT_OFS:  st_next.rdata[8:0] = st_reg.cont;
                VWD_UGAIN_OFS: st_next.rdata[8:0] = st_reg.ug;
                VWD_VGAIN_OFS: st_next.rdata[8:0] = st_reg.vg;
                VWD_STAT_OFS: begin
                    st_next.rdata[10:0] = porch_w;
                    st_next.rdata[VWD_STAT_ACC+:6] = st_reg.acc;
                    st_next.rdata[VWD_STAT_SKIP] = st_reg.skip;
                    st_next.rdata[VWD_STAT_HACT] = st_reg.hact;
                    st_next.rdata[VWD_STAT_VACT] = st_reg.vact;
                end
                default: st_next.rresp = VWD_RESP_SLVERR;
            endcase
        end
        // line and field counters
        st_next.hs_d = HSYNC_N;
        st_next.vs_d = VSYNC_N;
        if (hs_fall)
            st_next.hcnt = 11'd0;
        else if (PIX_EN && st_reg.hcnt != 11'h7FF)
            st_next.hcnt = st_reg.hcnt + 11'd1;
        if (vs_rise)
            st_next.vcnt = 11'd0;
        else if (HALF_LINE && st_reg.vcnt != 11'h7FF)
            st_next.vcnt = st_reg.vcnt + 11'd1;
        // temporal skip decision, taken once per unit, at its first field start
        if (vs_rise && st_reg.skipc[5:0] != 6'd0) begin
            if (!st_reg.armed) begin
                // field mode starts at the parity opposite the first drop
                if (st_reg.skipc[VWD_SKIP_FIELD])
                    st_next.armed = FIELD_ODD != st_reg.skipc[VWD_SKIP_ALIGN];
                else
                    st_next.armed = FIELD_ODD;
                unit = st_next.armed;
            end else begin
                unit = st_reg.skipc[VWD_SKIP_FIELD] || FIELD_ODD;
            end
            if (unit) begin
                // error-diffusion step spreads drops evenly
                if (sum_w >= seq_w) begin
                    st_next.skip = 1'b1;
                    st_next.acc = 6'(sum_w - seq_w);
                end else begin
                    st_next.skip = 1'b0;
                    st_next.acc = sum_w[5:0];
                end
            end
        end
        if (st_reg.skipc[5:0] == 6'd0)
            st_next.skip = 1'b0;
        // a zero write restarts the sequence, even mid unit
        if (wr_zero) begin
            st_next.acc = 6'd0;
            st_next.armed = 1'b0;
            st_next.skip = 1'b0;
        end
        // pixel path, one register stage
        st_next.pv = 1'b0;
        if (PIX_EN) begin
            st_next.hact = h_in;
            st_next.vact = v_in;
            st_next.act = h_in && v_in && !st_reg.skip;
            st_next.pv = h_in && v_in && !st_reg.skip;
            st_next.cr = st_reg.hcnt[0];
            st_next.y = (yprod[16:8] > 9'd255) ? 8'hFF : yprod[15:8];
            st_next.u = vwd_sat_s($signed(U_IN)
                                  * $signed({2'b00, st_reg.ug}));
            st_next.v = vwd_sat_s($signed(V_IN)
                                  * $signed({2'b00, st_reg.vg}));
            // hue has no meaning for pal or secam chroma
            st_next.ph = st_reg.ctrl[VWD_CTRL_PAL] ? PHASE_IN
                         : PHASE_IN + hue_c;
        end
        if (st_reg.skip) begin
            st_next.act = 1'b0;
            st_next.pv = 1'b0;
        end
        // outside pixel port output mode hact and vact stay low; act still follows the window
        if (!st_reg.ctrl[VWD_CTRL_PPOUT]) begin
            st_next.hact = 1'b0;
            st_next.vact = 1'b0;
        end
    end
    // state register; reset clears the skip sequence too
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg <= '0;
            st_reg.hs_d <= 1'b1;
            st_reg.vs_d <= 1'b1;
            st_reg.cont <= {1'b1, VWD_CONT_RST};
            st_reg.ug <= VWD_GAIN_RST;
            st_reg.vg <= VWD_GAIN_RST;
        end else begin
            st_reg <= st_next;
        end
    end
    // bus handshakes come straight from state
    assign S_AXI_AWREADY = !st_reg.aw_got && !st_reg.bvalid;
    assign S_AXI_WREADY  = !st_reg.w_got && !st_reg.bvalid;
    assign S_AXI_BVALID  = st_reg.bvalid;
    assign S_AXI_BRESP   = st_reg.bresp;
    assign S_AXI_ARREADY = !st_reg.rvalid;
    assign S_AXI_RVALID  = st_reg.rvalid;
    assign S_AXI_RDATA   = st_reg.rdata;
    assign S_AXI_RRESP   = st_reg.rresp;
    assign Y_OUT         = st_reg.y;
    assign U_OUT         = st_reg.u;
    assign V_OUT         = st_reg.v;
    assign PHASE_OUT     = st_reg.ph;
    assign PIX_VALID     = st_reg.pv;
    assign CHROMA_IS_CR  = st_reg.cr;
    assign HORIZ_WINDOW_WIDTH_OUT   = st_reg.hact;
    assign VERT_WINDOW_LINES_OUT   = st_reg.vact;
    assign ACTIVE_OUT    = st_reg.act;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_pix_at_delay;
        PIX_EN && st_reg.hcnt == hd_w && hw_w != 11'd0 && v_in
        && !st_reg.skip;
    endsequence
    a_skip_holds_low: assert property (st_reg.skip |=> !ACTIVE_OUT)
        else $error("active high during skipped unit");
    a_first_pixel: assert property (s_pix_at_delay |=> ACTIVE_OUT)
        else $error("window did not open at start delay");
    a_hact_open: assert property ((s_pix_at_delay
        and st_reg.ctrl[VWD_CTRL_PPOUT]) |=> HORIZ_WINDOW_WIDTH_OUT)
        else $error("horizontal active did not rise at delay");
    a_cr_parity: assert property (PIX_EN
        |=> CHROMA_IS_CR == $past(st_reg.hcnt[0]))
        else $error("chroma slot parity wrong");
    a_zero_restart: assert property (wr_zero |=> st_reg.acc == 6'd0
        && !st_reg.armed)
        else $error("zero write did not restart sequence");
    a_off_no_skip: assert property (st_reg.skipc[5:0] == 6'd0
        |-> !st_reg.skip)
        else $error("skip while decimation disabled");
    a_acc_bound: assert property ({1'b0, st_reg.acc} < seq_w)
        else $error("accumulator left the sequence range");
    a_ppin_open: assert property (st_reg.ctrl[VWD_CTRL_PPIN] && PIX_EN
        && !st_reg.skip |=> ACTIVE_OUT)
        else $error("window applied in pixel port input mode");
    a_bresp_both: assert property ($rose(S_AXI_BVALID)
        |-> $past(st_reg.aw_got && st_reg.w_got))
        else $error("write answer before both halves");
endmodule

// File: tb/vwd_capture_model.sv
// capture side model: counts window pixels and timing per line
`timescale 1ns/100ps
module vwd_capture_model (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   hsync_n,
    input  wire logic   pix_valid,
    input  wire logic   chroma_is_cr,
    input  wire logic   hact,
    output logic [10:0] pix_cnt,
    output logic [10:0] hact_cnt,
    output logic        first_cr
);
    logic hs_reg; // last sync level, for edge finding
    // counts restart at each sync fall; one line per field here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {hs_reg, pix_cnt, hact_cnt, first_cr} <= '0;
        end else begin
            hs_reg <= hsync_n;
            if (hs_reg && !hsync_n) begin
                {pix_cnt, hact_cnt} <= '0;
            end else begin
                hact_cnt <= hact_cnt + 11'(hact);
                pix_cnt  <= pix_cnt + 11'(pix_valid);
                // chroma kind of the first pixel taken
                if (pix_valid && pix_cnt == '0) begin
                    first_cr <= chroma_is_cr;
                end
            end
        end
    end
endmodule

// File: tb/vwd_top_tb.sv
// bench: register access, window, skip pattern and colour checks
`timescale 1ns/100ps
module vwd_top_tb;
    import vwd_pkg::*;
    logic        CORE_CLK, RST_N, S_AXI_AWVALID, S_AXI_AWREADY;
    logic        S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic        PIX_EN, HSYNC_N, VSYNC_N, HALF_LINE, FIELD_ODD, PIX_VALID;
    logic        CHROMA_IS_CR, HORIZ_WINDOW_WIDTH_OUT, VERT_WINDOW_LINES_OUT, ACTIVE_OUT;
    logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, Y_IN, U_IN, V_IN, PHASE_IN;
    logic [7:0]  Y_OUT, U_OUT, V_OUT, PHASE_OUT;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
    logic [10:0] pix_cnt, hact_cnt;
    logic        first_cr;
    int          fails = 0;
    int          cmp_count = 0;
    vwd_top dut (.*);
    // far side: capture logic counting what it is handed
    vwd_capture_model cap (.clk(CORE_CLK), .rst_n(RST_N),
        .hsync_n(HSYNC_N), .pix_valid(PIX_VALID), .hact(HORIZ_WINDOW_WIDTH_OUT),
        .chroma_is_cr(CHROMA_IS_CR), .pix_cnt(pix_cnt),
        .hact_cnt(hact_cnt), .first_cr(first_cr));
    initial begin
        CORE_CLK = 1'b0;
        forever #25 CORE_CLK = ~CORE_CLK;
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic to();
        fails++;
        stop_test();
    endtask
    // bounded wait; returns mid-cycle, before the edge that takes the answer
    task automatic hs(ref logic s);
        for (int n = 0; s !== 1'b1; n++) begin
            if (n > 200) to();
            @(negedge CORE_CLK);
        end
    endtask
    // write one word; address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, ta, tw;
        {aw, w} = 2'b11;
        @(posedge CORE_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
        for (int n = 0; aw || w; n++) begin
            if (n > 200) to();
            @(negedge CORE_CLK);
            {ta, tw} = {aw & S_AXI_AWREADY, w & S_AXI_WREADY};
            @(posedge CORE_CLK);
            if (ta) S_AXI_AWVALID <= 1'b0;
            if (tw) S_AXI_WVALID <= 1'b0;
            {aw, w} = {aw & !ta, w & !tw};
        end
        hs(S_AXI_BVALID);
        @(posedge CORE_CLK);
        rsp = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge CORE_CLK);
        {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
        hs(S_AXI_ARREADY);
        @(posedge CORE_CLK);
        S_AXI_ARVALID <= 1'b0;
        hs(S_AXI_RVALID);
        @(posedge CORE_CLK);
        {rsp, rd} = {S_AXI_RRESP, S_AXI_RDATA};
        S_AXI_RREADY <= 1'b0;
    endtask
    // one field: sync, hl half lines, then a 12 pixel line
    task automatic field(input logic odd, input int hl);
        @(posedge CORE_CLK);
        {VSYNC_N, FIELD_ODD} <= {1'b0, odd};
        @(posedge CORE_CLK);
        VSYNC_N <= 1'b1;
        repeat (hl) begin
            @(posedge CORE_CLK) HALF_LINE <= 1'b1;
            @(posedge CORE_CLK) HALF_LINE <= 1'b0;
        end
        @(posedge CORE_CLK) HSYNC_N <= 1'b0;
        @(posedge CORE_CLK) HSYNC_N <= 1'b1;
        repeat (12) begin
            @(posedge CORE_CLK) PIX_EN <= 1'b1;
            @(posedge CORE_CLK) PIX_EN <= 1'b0;
        end
        repeat (3) @(posedge CORE_CLK);
    endtask
    task automatic regs_check();
        rd_reg(VWD_UGAIN_OFS);
        chk("u gain", {23'h0, VWD_GAIN_RST}, rd);
        rd_reg(VWD_SKIP_OFS);
        chk("skip reg", 32'h0, rd);
        rd_reg(8'h30);
        chk("unmapped read", {30'h0, VWD_RESP_SLVERR}, {30'h0, rsp});
        wr(8'h30, 32'hFFFF_FFFF);
        chk("unmapped write", {30'h0, VWD_RESP_SLVERR}, {30'h0, rsp});
    endtask
    // window placement, width, chroma order, vertical span, porch
    task automatic window_check();
        int hl[4] = '{1, 2, 9, 10};
        int ex[4] = '{0, 5, 5, 0};
        wr(VWD_CTRL_OFS, 32'h2);
        wr(VWD_HDLY_OFS, 32'h3);
        wr(VWD_HWID_OFS, 32'h5);
        wr(VWD_VDLY_OFS, 32'h2);
        wr(VWD_VLIN_OFS, 32'h8);
        foreach (hl[i]) begin
            field(1'b1, hl[i]);
            chk("lines", ex[i], {21'h0, pix_cnt});
            chk("vact", ex[i] != 0, {31'h0, VERT_WINDOW_LINES_OUT});
        end
        chk("first cr", 32'h1, {31'h0, first_cr});
        chk("hact cycles", 32'hA, {21'h0, hact_cnt});
        wr(VWD_WMSB_OFS, 32'h4);
        field(1'b1, 2);
        chk("delay msb", 32'h0, {21'h0, pix_cnt});
        wr(VWD_WMSB_OFS, 32'h0);
        wr(VWD_HDLY_OFS, 32'h4);
        field(1'b1, 2);
        chk("first cb", 32'h0, {31'h0, first_cr});
        rd_reg(VWD_STAT_OFS);
        chk("porch ntsc", 32'd901, {21'h0, rd[10:0]});
        wr(VWD_CTRL_OFS, 32'h4);
        field(1'b1, 1);
        chk("input mode", 32'd12, {21'h0, pix_cnt});
        chk("active", 32'h1, {31'h0, ACTIVE_OUT});
        wr(VWD_CTRL_OFS, 32'h3);
        rd_reg(VWD_STAT_OFS);
        chk("porch pal", 32'd1126, {21'h0, rd[10:0]});
    endtask
    task automatic colour_check();
        wr(VWD_CONT_OFS, 32'h80);
        wr(VWD_UGAIN_OFS, 32'h180);
        wr(VWD_VGAIN_OFS, 32'h40);
        wr(VWD_HUE_OFS, 32'h7F);
        field(1'b1, 2);
        chk("phase pal", 32'h20, {24'h0, PHASE_OUT});
        wr(VWD_CTRL_OFS, 32'h2);
        field(1'b1, 2);
        chk("phase clamp", 32'h60, {24'h0, PHASE_OUT});
        wr(VWD_HUE_OFS, 32'h10);
        field(1'b1, 2);
        chk("phase", 32'h30, {24'h0, PHASE_OUT});
        chk("luma", 32'h64, {24'h0, Y_OUT});
        chk("u", 32'h3C, {24'h0, U_OUT});
        chk("v", 32'hF0, {24'h0, V_OUT});
    endtask
    // whole ntsc sequence; m is the skip period in units
    task automatic seq_run(input logic [7:0] v, input int per, m,
                           input logic inv);
        wr(VWD_SKIP_OFS, {24'h0, v});
        for (int u = 1; u <= 120; u++) begin
            field(u[0] ^ inv, 2);
            chk("unit", ((u + per - 1) / per) % m == 0 ? 0 : 5,
                {21'h0, pix_cnt});
        end
        wr(VWD_SKIP_OFS, 32'h0);
    endtask
    initial begin
        {RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
        {S_AXI_ARVALID, S_AXI_RREADY, PIX_EN, HALF_LINE} = '0;
        {HSYNC_N, VSYNC_N, FIELD_ODD, S_AXI_WSTRB} = 7'h6F;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
        {Y_IN, U_IN, V_IN, PHASE_IN} = 32'hC828_C020;
        repeat (12) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        regs_check();
        window_check();
        colour_check();
        seq_run(8'h02, 2, 30, 1'b0);
        seq_run(8'h9E, 1, 2, 1'b0);
        seq_run(8'hDE, 1, 2, 1'b1);
        seq_run(8'h00, 1, 121, 1'b0);
        stop_test();
    end
endmodule
